//--- logic/hds_dev.sv
// Purpose: processor end: bus release on hold and master access to on-chip ram
// Assumes: master and processor share clk; pins synchronous
// Notes: core bus and execution modelled by user-side ports only
`timescale 1ns/1ns
module hds_dev
  import hds_pkg::*;
#(
  parameter int RAM_WORDS = HDS_RAM_9K
) (
  input wire logic clk,
  input wire logic rst_n,
  hds_if.dev bus,
  input wire logic concurrent_run_select,
  input wire logic core_bus_drive,
  input wire logic core_fetch,
  input wire logic [HDS_AW-1:0] core_addr,
  input wire logic [HDS_DW-1:0] core_wdata,
  output logic core_run,
  output logic core_holding,
  output logic ram_write_seen
);
  // responding range per ram size; bits 15:14 never reach the decode
  localparam logic [13:0] LIM = (RAM_WORDS == HDS_RAM_1K) ? HDS_LIM_1K :
                                (RAM_WORDS == HDS_RAM_3K) ? HDS_LIM_3K : HDS_LIM_9K;
  hds_hold_t st_r, st_nxt;
  logic ack_n_r, ack_n_nxt;
  logic grant_n_r, grant_n_nxt;
  logic aoe_r, aoe_nxt;
  logic doe_r, doe_nxt;
  logic [HDS_AW-1:0] ao_r, ao_nxt;
  logic [HDS_DW-1:0] do_r, do_nxt;
  logic run_r, run_nxt;
  logic hold_r, hold_nxt;
  logic wseen_r, wseen_nxt;
  logic access_select_pulse_d_r, access_select_pulse_d_nxt;
  logic [13:0] ram_addr;
  logic in_range;
  logic sel;
  logic ram_we;
  logic [HDS_DW-1:0] ram_rd;

  assign ram_addr = bus.addr[HDS_DEC_MSB:0];
  assign in_range = (ram_addr <= LIM);
  // an access needs grant, acknowledge and pulse all low at once
  assign sel = (st_r == HDS_HS_GRANT) && !bus.access_select_pulse_n && !grant_n_r
    && !ack_n_r;
  // write once per pulse, on its falling edge; a long pulse only waits
  assign ram_we = sel && access_select_pulse_d_r && !bus.rw && in_range;

  // out-of-range writes are dropped before the array, reads stay floated
  hds_ram #(.DEPTH(RAM_WORDS)) u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(bus.data),
    .rdata(ram_rd)
  );

  always_comb begin
    st_nxt = st_r;
    ack_n_nxt = ack_n_r;
    grant_n_nxt = 1'b1;
    aoe_nxt = 1'b0;
    doe_nxt = 1'b0;
    ao_nxt = ao_r;
    do_nxt = do_r;
    case (st_r)
      HDS_HS_RUN: begin
        ack_n_nxt = 1'b1;
        // outside hold the grant pin reports fetches
        grant_n_nxt = !core_fetch;
        aoe_nxt = core_bus_drive;
        doe_nxt = core_bus_drive;
        ao_nxt = core_addr;
        do_nxt = core_wdata;
        if (!bus.hold_n) begin
          // float first, acknowledge one cycle later
          aoe_nxt = 1'b0;
          doe_nxt = 1'b0;
          grant_n_nxt = 1'b1;
          st_nxt = HDS_HS_ACK;
        end
      end
      HDS_HS_ACK: begin
        ack_n_nxt = 1'b0;
        if (bus.hold_n) begin
          ack_n_nxt = 1'b1;
          st_nxt = HDS_HS_RUN;
        end else if (!ack_n_r && !bus.sram_access_request_n
                     && concurrent_run_select) begin
          // grant only once the master has seen the acknowledge
          grant_n_nxt = 1'b0;
          st_nxt = HDS_HS_GRANT;
        end
      end
      HDS_HS_GRANT: begin
        ack_n_nxt = 1'b0;
        grant_n_nxt = 1'b0;
        if (sel && bus.rw && in_range) begin
          // read data lags the pulse by a cycle: pins come from flops
          doe_nxt = 1'b1;
          do_nxt = ram_rd;
        end
        if (bus.hold_n) begin
          // hold gone: drop grant and acknowledge together, no extra ack cycle
          ack_n_nxt = 1'b1;
          grant_n_nxt = 1'b1;
          doe_nxt = 1'b0;
          st_nxt = HDS_HS_RUN;
        end else if (bus.sram_access_request_n || !concurrent_run_select) begin
          // request or run select gone: back to plain hold
          grant_n_nxt = 1'b1;
          doe_nxt = 1'b0;
          st_nxt = HDS_HS_ACK;
        end
      end
      default: begin
        st_nxt = HDS_HS_RUN;
        ack_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= HDS_HS_RUN;
      ack_n_r <= 1'b1;
      grant_n_r <= 1'b1;
      aoe_r <= 1'b0;
      doe_r <= 1'b0;
      ao_r <= '0;
      do_r <= HDS_DATA_RST;
    end else begin
      st_r <= st_nxt;
      ack_n_r <= ack_n_nxt;
      grant_n_r <= grant_n_nxt;
      aoe_r <= aoe_nxt;
      doe_r <= doe_nxt;
      ao_r <= ao_nxt;
      do_r <= do_nxt;
    end
  end

  // core status: only cycles wholly inside hold count as holding
  always_comb begin
    run_nxt = 1'b1;
    hold_nxt = 1'b0;
    if ((st_r != HDS_HS_RUN) && (st_nxt != HDS_HS_RUN)) begin
      hold_nxt = 1'b1;
      // select 0 keeps the core running, select 1 parks it
      run_nxt = !concurrent_run_select;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_r <= 1'b1;
      hold_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      hold_r <= hold_nxt;
    end
  end

  // pulse edge tracker starts at the idle level, so no false write edge
  always_comb begin
    access_select_pulse_d_nxt = bus.access_select_pulse_n;
    wseen_nxt = ram_we;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      access_select_pulse_d_r <= 1'b1;
      wseen_r <= 1'b0;
    end else begin
      access_select_pulse_d_r <= access_select_pulse_d_nxt;
      wseen_r <= wseen_nxt;
    end
  end

  // every pin and status output comes straight from a register
  assign bus.bus_release_ack_n = ack_n_r;
  assign bus.sram_grant_n = grant_n_r;
  assign bus.addr_dev = ao_r;
  assign bus.addr_dev_oe = aoe_r;
  assign bus.data_dev = do_r;
  assign bus.data_dev_oe = doe_r;
  assign core_run = run_r;
  assign core_holding = hold_r;
  assign ram_write_seen = wseen_r;
endmodule

//--- logic/hds_if.sv
// Purpose: pin-level link between the processor port and the master
// Assumes: all pins sampled on clk
// Notes: bus wires resolved here from the enables
`timescale 1ns/1ns
interface hds_if (
  input wire logic clk
);
  import hds_pkg::*;
  logic hold_n;
  logic bus_release_ack_n;
  logic sram_access_request_n;
  logic sram_grant_n;
  logic access_select_pulse_n;
  logic rw;
  logic [HDS_AW-1:0] addr_dev;
  logic addr_dev_oe;
  logic [HDS_AW-1:0] addr_mst;
  logic addr_mst_oe;
  logic [HDS_DW-1:0] data_dev;
  logic data_dev_oe;
  logic [HDS_DW-1:0] data_mst;
  logic data_mst_oe;
  logic [HDS_AW-1:0] addr;
  logic [HDS_DW-1:0] data;
  assign addr = addr_dev_oe ? addr_dev : (addr_mst_oe ? addr_mst : '0);
  assign data = data_dev_oe ? data_dev : (data_mst_oe ? data_mst : '0);
  modport dev (
    input hold_n, sram_access_request_n, access_select_pulse_n, rw, addr, data,
    output bus_release_ack_n, sram_grant_n, addr_dev, addr_dev_oe, data_dev, data_dev_oe
  );
  modport mst (
    input bus_release_ack_n, sram_grant_n, addr, data,
    output hold_n, sram_access_request_n, access_select_pulse_n, rw,
    output addr_mst, addr_mst_oe, data_mst, data_mst_oe
  );
endinterface

//--- logic/hds_mst.sv
// Purpose: master end: takes hold, then one ram read or write per command
// Assumes: shares clk with the processor end
// Notes: strobe held for a fixed count, so reads see registered data
`timescale 1ns/1ns
module hds_mst
  import hds_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  hds_if.mst bus,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [HDS_AW-1:0] cmd_addr,
  input wire logic [HDS_DW-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [HDS_DW-1:0] rsp_rdata,
  output logic sys_ready
);
  hds_mst_t st_r, st_nxt;
  logic hold_n_r, hold_n_nxt;
  logic req_n_r, req_n_nxt;
  logic access_select_pulse_n_r, access_select_pulse_n_nxt;
  logic rw_r, rw_nxt;
  logic aoe_r, aoe_nxt;
  logic doe_r, doe_nxt;
  logic [HDS_AW-1:0] a_r, a_nxt;
  logic [HDS_DW-1:0] d_r, d_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic rv_r, rv_nxt;
  logic [HDS_DW-1:0] rd_r, rd_nxt;
  logic sr_r, sr_nxt;

  always_comb begin
    st_nxt = st_r;
    hold_n_nxt = hold_n_r;
    req_n_nxt = req_n_r;
    access_select_pulse_n_nxt = access_select_pulse_n_r;
    rw_nxt = rw_r;
    aoe_nxt = aoe_r;
    doe_nxt = doe_r;
    a_nxt = a_r;
    d_nxt = d_r;
    cnt_nxt = cnt_r;
    rdy_nxt = 1'b0;
    rv_nxt = 1'b0;
    rd_nxt = rd_r;
    sr_nxt = !bus.bus_release_ack_n;
    case (st_r)
      HDS_MS_IDLE: begin
        rdy_nxt = 1'b1;
        if (cmd_valid && rdy_r) begin
          rdy_nxt = 1'b0;
          rw_nxt = cmd_read;
          a_nxt = cmd_addr;
          d_nxt = cmd_wdata;
          hold_n_nxt = 1'b0;
          st_nxt = HDS_MS_HOLD;
        end
      end
      HDS_MS_HOLD: if (!bus.bus_release_ack_n) begin
        req_n_nxt = 1'b0;
        aoe_nxt = 1'b1;
        doe_nxt = !rw_r;
        st_nxt = HDS_MS_REQ;
      end
      HDS_MS_REQ: if (!bus.sram_grant_n) begin
        access_select_pulse_n_nxt = 1'b0;
        cnt_nxt = HDS_ACCESS_SELECT_PULSE_WAIT;
        st_nxt = HDS_MS_ACCESS_SELECT_PULSE;
      end
      HDS_MS_ACCESS_SELECT_PULSE: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h0) begin
          rd_nxt = bus.data;
          access_select_pulse_n_nxt = 1'b1;
          st_nxt = HDS_MS_DONE;
        end
      end
      HDS_MS_DONE: begin
        req_n_nxt = 1'b1;
        aoe_nxt = 1'b0;
        doe_nxt = 1'b0;
        hold_n_nxt = 1'b1;
        rv_nxt = rw_r;
        st_nxt = HDS_MS_REL;
      end
      HDS_MS_REL: if (bus.bus_release_ack_n) begin
        st_nxt = HDS_MS_IDLE;
      end
      default: st_nxt = HDS_MS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= HDS_MS_IDLE;
      hold_n_r <= 1'b1;
      req_n_r <= 1'b1;
      access_select_pulse_n_r <= 1'b1;
      rw_r <= 1'b1;
      aoe_r <= 1'b0;
      doe_r <= 1'b0;
      a_r <= '0;
      d_r <= HDS_DATA_RST;
      cnt_r <= 4'h0;
      rdy_r <= 1'b0;
      rv_r <= 1'b0;
      rd_r <= HDS_DATA_RST;
      sr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hold_n_r <= hold_n_nxt;
      req_n_r <= req_n_nxt;
      access_select_pulse_n_r <= access_select_pulse_n_nxt;
      rw_r <= rw_nxt;
      aoe_r <= aoe_nxt;
      doe_r <= doe_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      sr_r <= sr_nxt;
    end
  end

  assign bus.hold_n = hold_n_r;
  assign bus.sram_access_request_n = req_n_r;
  assign bus.access_select_pulse_n = access_select_pulse_n_r;
  assign bus.rw = rw_r;
  assign bus.addr_mst = a_r;
  assign bus.addr_mst_oe = aoe_r;
  assign bus.data_mst = d_r;
  assign bus.data_mst_oe = doe_r;
  assign cmd_ready = rdy_r;
  assign rsp_valid = rv_r;
  assign rsp_rdata = rd_r;
  assign sys_ready = sr_r;
endmodule

//--- logic/hds_pkg.sv
// Purpose: shared constants for the hold / on-chip ram access port
// Assumes: one clock, synchronous active-low reset
// Notes: ram size chosen by parameter on the device end
package hds_pkg;
  localparam int HDS_AW = 16;
  localparam int HDS_DW = 16;
  localparam int HDS_DEC_MSB = 13;
  localparam int HDS_RAM_9K = 9216;
  localparam int HDS_RAM_3K = 3072;
  localparam int HDS_RAM_1K = 1024;
  localparam logic [13:0] HDS_LIM_9K = 14'h23FF;
  localparam logic [13:0] HDS_LIM_3K = 14'h0BFF;
  localparam logic [13:0] HDS_LIM_1K = 14'h03FF;
  localparam logic [15:0] HDS_DATA_RST = 16'h0000;
  localparam logic [7:0] HDS_PC_RST = 8'h00;
  localparam logic [3:0] HDS_ACCESS_SELECT_PULSE_WAIT = 4'h3;
  typedef enum logic [1:0] {
    HDS_HS_RUN = 2'b00,
    HDS_HS_ACK = 2'b01,
    HDS_HS_GRANT = 2'b10
  } hds_hold_t;
  typedef enum logic [2:0] {
    HDS_MS_IDLE = 3'b000,
    HDS_MS_HOLD = 3'b001,
    HDS_MS_REQ = 3'b010,
    HDS_MS_ACCESS_SELECT_PULSE = 3'b011,
    HDS_MS_DONE = 3'b100,
    HDS_MS_REL = 3'b101
  } hds_mst_t;
endpackage

//--- logic/hds_ram.sv
// Purpose: single-access ram array of the processor
// Assumes: one port, write on we, registered read
// Notes: depth is a parameter
`timescale 1ns/1ns
module hds_ram
  import hds_pkg::*;
#(
  parameter int DEPTH = HDS_RAM_9K
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [13:0] addr,
  input wire logic [HDS_DW-1:0] wdata,
  output logic [HDS_DW-1:0] rdata
);
  logic [HDS_DW-1:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- tb/hds_chk_assertions.sv
// Purpose: protocol checks on the processor / master link
// Assumes: one clock, synchronous active-low reset
// Notes: limit parameter must match the device ram size
`timescale 1ns/1ns
module hds_chk
  import hds_pkg::*;
#(
  parameter logic [13:0] LIM = HDS_LIM_9K
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic concurrent_run_select,
  input wire logic hold_n,
  input wire logic bus_release_ack_n,
  input wire logic sram_access_request_n,
  input wire logic sram_grant_n,
  input wire logic access_select_pulse_n,
  input wire logic rw,
  input wire logic [HDS_AW-1:0] addr,
  input wire logic addr_dev_oe,
  input wire logic data_dev_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic hold_on;
  logic acc_rd;
  assign hold_on = !bus_release_ack_n;
  assign acc_rd = hold_on && !sram_grant_n && !access_select_pulse_n && rw;
  a_float_on_hold: assert property (
    $fell(hold_n) |-> ##[1:2] (!addr_dev_oe && !data_dev_oe)) else $error("bus not floated");
  a_ack_follows: assert property (
    $fell(hold_n) |-> ##[1:3] hold_on) else $error("no acknowledge");
  a_floated_in_ack: assert property (
    hold_on |-> !addr_dev_oe && (!data_dev_oe || $past(acc_rd))) else $error("drive during hold");
  a_ack_needs_hold: assert property (
    hold_on |-> $past(!hold_n)) else $error("ack without hold");
  a_ack_release: assert property (
    hold_on && hold_n |-> ##[1:2] !hold_on) else $error("ack not released");
  a_grant_answer: assert property (
    hold_on && concurrent_run_select && $fell(sram_access_request_n)
    |-> ##[1:2] !sram_grant_n) else $error("grant missing");
  a_grant_cause: assert property (
    hold_on && $past(hold_on) && !sram_grant_n |-> $past(!sram_access_request_n))
    else $error("grant without request");
  a_grant_drop: assert property (
    hold_on && $rose(sram_access_request_n) |-> ##[0:1] sram_grant_n) else $error("grant held");
  a_no_grant_sel0: assert property (
    !concurrent_run_select && hold_on |-> sram_grant_n) else $error("grant with run select 0");
  a_read_drives: assert property (
    acc_rd && $past(acc_rd) && addr[13:0] <= LIM |-> data_dev_oe) else $error("read not driven");
  a_write_quiet: assert property (
    hold_on && !rw |-> !data_dev_oe) else $error("driven on write");
endmodule

//--- tb/hold_dma_sram_port_tb.sv
// Purpose: random ram traffic through hold, aliasing, range and refusal cases
// Assumes: 9K-word device end
// Notes: unwritten ram words are never read back
`timescale 1ns/1ns
module hold_dma_sram_port_tb;
  import hds_pkg::*;
  logic clk, rst_n, sel, core_bus_drive, core_fetch, core_run, core_holding, ram_write_seen;
  logic [15:0] core_addr, core_wdata, cmd_addr, cmd_wdata, rsp_rdata, a, d, q, b;
  logic cmd_valid, cmd_read, cmd_ready, rsp_valid, sys_ready;
  logic [15:0] ref_mem [0:16383];
  integer seed = 85985;
  integer err_count = 0;
  integer comparisons = 0;
  integer wr_seen = 0;
  integer i;
  hds_if bus_if (.clk(clk));
  hds_dev hds_dev_i (.clk(clk), .rst_n(rst_n), .bus(bus_if), .concurrent_run_select(sel),
    .core_bus_drive(core_bus_drive), .core_fetch(core_fetch), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_run(core_run), .core_holding(core_holding),
    .ram_write_seen(ram_write_seen));
  hds_mst hds_mst_i (.clk(clk), .rst_n(rst_n), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sys_ready(sys_ready));
  hds_chk hds_chk_i (.clk(clk), .rst_n(rst_n), .concurrent_run_select(sel),
    .hold_n(bus_if.hold_n), .bus_release_ack_n(bus_if.bus_release_ack_n),
    .sram_access_request_n(bus_if.sram_access_request_n), .sram_grant_n(bus_if.sram_grant_n),
    .access_select_pulse_n(bus_if.access_select_pulse_n), .rw(bus_if.rw),
    .addr(bus_if.addr), .addr_dev_oe(bus_if.addr_dev_oe), .data_dev_oe(bus_if.data_dev_oe));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    sel = s;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // one command; bounded waits keep a stuck handshake from hanging the run
  task automatic do_cmd(input logic rd, input logic [15:0] ad, input logic [15:0] wd);
    integer n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = ad;
    cmd_wdata = wd;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rd && rsp_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    q = rsp_rdata;
    chk({15'h0000, n >= 100}, 16'h0000);
  endtask
  // random core activity also checks that hold ignores it
  always @(negedge clk) begin
    core_fetch = 1'($random(seed));
    core_bus_drive = 1'($random(seed));
    core_addr = 16'($random(seed));
    core_wdata = 16'($random(seed));
    if (ram_write_seen === 1'b1) wr_seen++;
    if (rst_n && core_holding === 1'b1) chk({15'h0000, core_run}, {15'h0000, ~sel});
  end
  initial begin
    #40000;
    err_count++;
    $display("Error at %0t: got %h expected %h", $time, 16'h0000, 16'h0001);
    print_verdict();
  end
  initial begin
    {cmd_valid, cmd_read, cmd_addr, cmd_wdata} = '0;
    {core_fetch, core_bus_drive, core_addr, core_wdata} = '0;
    do_reset(1'b1);
    for (i = 0; i < 24; i++) begin
      a = 16'($random(seed));
      a[13:0] = a[13:0] % 14'h2400;
      if (i == 0) a = 16'h23FF;
      if (i == 1) a = 16'h4000;
      d = 16'($random(seed));
      do_cmd(1'b0, a, d);
      ref_mem[a[13:0]] = d;
      b = 16'($random(seed));
      a[15:14] = b[1:0];
      do_cmd(1'b1, a, 16'h0000);
      chk(q, ref_mem[a[13:0]]);
    end
    do_cmd(1'b0, 16'h2400, 16'hA5A5);
    do_cmd(1'b1, 16'hE400, 16'h0000);
    chk(q, 16'h0000);
    repeat (4) @(negedge clk);
    chk(wr_seen[15:0], 16'h0018);
    $display("test traffic done");
    do_reset(1'b0);
    do_cmd(1'b0, 16'h0001, 16'h5A5A);
    repeat (30) @(negedge clk);
    chk({15'h0000, bus_if.sram_grant_n}, 16'h0001);
    chk({15'h0000, sys_ready}, 16'h0001);
    chk(wr_seen[15:0], 16'h0018);
    $display("test refused access done");
    do_reset(1'b1);
    print_verdict();
  end
endmodule
